/* flsb_chk.sv */
// port assertions for the fault latch status bank
`timescale 1ns/1ps
module flsb_chk (
  input wire logic clk,
  input wire logic rst,
  input wire flsb_pkg::flsb_req_s host_req,
  input wire flsb_pkg::flsb_rsp_s host_rsp,
  input wire flsb_pkg::flsb_in_fault_s in2_fault,
  input wire flsb_pkg::flsb_out_fault_s out1_fault,
  input wire flsb_pkg::flsb_out_fault_s out2_fault,
  input wire logic analog_regulator_short,
  input wire logic adc1_overload,
  input wire logic adc2_overload,
  input wire flsb_pkg::flsb_int_src_s int_src,
  input wire logic channel_summary_fault_flag,
  input wire logic fault_irq
);
  import flsb_pkg::*;
  logic rd;
  logic [2:0] up_ff;
  assign rd = host_req.req && !host_req.we;
  // edges since reset; the two sync flops lose anything seen earlier
  always_ff @(posedge clk or posedge rst) begin
    if (rst) up_ff <= 3'h0;
    else if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // a read of input2, output1 or the interrupt group shows every condition seen three edges before it
  property p_in2_sticky;
    rd && host_req.addr == FLSB_ADDR_IN2 && up_ff == 3'h7
      |=> (host_rsp.rdata & $past(in2_fault, 4)) == $past(in2_fault, 4);
  endproperty
  a_in2_sticky: assert property (p_in2_sticky)
    else $error("input2 fault lost");
  property p_out1_sticky;
    rd && host_req.addr == FLSB_ADDR_OUT1 && up_ff == 3'h7
      |=> (host_rsp.rdata[7:4] & $past(out1_fault, 4)) == $past(out1_fault, 4);
  endproperty
  a_out1_sticky: assert property (p_out1_sticky) else $error("output1 fault lost");
  property p_int_sticky;
    rd && host_req.addr == FLSB_ADDR_INT1 && up_ff == 3'h7
      |=> (host_rsp.rdata & $past(int_src, 4)) == $past(int_src, 4);
  endproperty
  a_int_sticky: assert property (p_int_sticky)
    else $error("interrupt lost");
  property p_res38;
    rd && host_req.addr == FLSB_ADDR_OUT1 |=> host_rsp.rdata[1:0] == 2'h0;
  endproperty
  a_res38: assert property (p_res38) else $error("output1 reserved bits set");
  property p_res39;
    rd && host_req.addr == FLSB_ADDR_OUT2 |=> host_rsp.rdata[3:2] == 2'h0;
  endproperty
  a_res39: assert property (p_res39) else $error("output2 reserved bits set");
  property p_mask38;
    host_req.req && host_req.we && host_req.addr == FLSB_ADDR_OUT1
      ##1 rd && host_req.addr == FLSB_ADDR_OUT1
      |=> host_rsp.rdata[3:2] == $past(host_req.wdata[3:2], 2);
  endproperty
  a_mask38: assert property (p_mask38) else $error("adc masks not kept");
  property p_summary;
    up_ff == 3'h7 && in2_fault != 8'h00 |-> ##4 channel_summary_fault_flag;
  endproperty
  a_summary: assert property (p_summary) else $error("summary flag missing");
  property p_irq;
    up_ff == 3'h7 && int_src != 8'h00 |-> ##4 fault_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output missing");
endmodule

bind flsb_top flsb_chk chk_u (.clk(clk), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
  .in2_fault(in2_fault), .out1_fault(out1_fault), .out2_fault(out2_fault),
  .analog_regulator_short(analog_regulator_short), .adc1_overload(adc1_overload),
  .adc2_overload(adc2_overload), .int_src(int_src),
  .channel_summary_fault_flag(channel_summary_fault_flag), .fault_irq(fault_irq));

/* flsb_host_model.sv */
// host side model issuing byte requests on the control port
`timescale 1ns/1ps
module flsb_host_model (
  input wire logic clk,
  output flsb_pkg::flsb_req_s host_req,
  input wire flsb_pkg::flsb_rsp_s host_rsp
);
  import flsb_pkg::*;
  initial host_req = '0;
  // request launched at the falling edge, left up so a next one can follow
  task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] keep;
    keep = (a == FLSB_ADDR_OUT1) ? 8'hFC : (a == FLSB_ADDR_OUT2) ? 8'hF3 : 8'hFF;
    @(negedge clk);
    host_req <= '{req: 1'b1, we: we, addr: a, wdata: d & keep};
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  // ack follows req one edge later, so take it in the low half after the answering edge
  task automatic rd(input logic [7:0] a, output logic [8:0] got);
    acc(1'b0, a, 8'h00);
    @(negedge clk);
    got = {host_rsp.ack, host_rsp.rdata};
    host_req.req <= 1'b0;
  endtask
endmodule

/* flsb_latch_bank.sv */
// synchronised sticky fault latches, cleared by a read of their register
`timescale 1ns/1ps

module flsb_latch_bank #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] cond,
  input wire logic clr,
  output logic [W-1:0] latched,
  output logic [W-1:0] live
);
  import flsb_pkg::*;

  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] lat;
  } flsb_lb_state_s;

  flsb_lb_state_s st_ff;
  flsb_lb_state_s nxt_st;

  // two stages before use; only sync2 reads sync1
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sync1 = cond;
    nxt_st.sync2 = st_ff.sync1;
    // set wins over the read clear so a fault in the clear cycle survives
    nxt_st.lat = (clr ? '0 : st_ff.lat) | st_ff.sync2;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign latched = st_ff.lat;
  assign live = st_ff.sync2;
endmodule

/* flsb_pkg.sv */
// constants and carrier types shared by the fault latch status bank
package flsb_pkg;

  // register addresses on the control port
  localparam logic [7:0] FLSB_ADDR_IN2 = 8'h37;
  localparam logic [7:0] FLSB_ADDR_OUT1 = 8'h38;
  localparam logic [7:0] FLSB_ADDR_OUT2 = 8'h39;
  localparam logic [7:0] FLSB_ADDR_INT1 = 8'h3A;

  // reset values
  localparam logic [7:0] FLSB_RST_IN2 = 8'h00;
  localparam logic [7:0] FLSB_RST_OUT1 = 8'h00;
  localparam logic [7:0] FLSB_RST_OUT2 = 8'h00;
  localparam logic [7:0] FLSB_RST_INT1 = 8'h00;
  localparam logic [7:0] FLSB_RDATA_NONE = 8'h00;

  // field positions in output1_fault_latch
  localparam int FLSB_O1_FAULT_LSB = 4;
  localparam int FLSB_O1_ADC1_MASK_BIT = 3;
  localparam int FLSB_O1_ADC2_MASK_BIT = 2;

  // field positions in output2_fault_latch
  localparam int FLSB_O2_FAULT_LSB = 4;
  localparam int FLSB_O2_REG_MASK_BIT = 1;
  localparam int FLSB_O2_REG_LATCH_BIT = 0;

  // widths of the latch groups
  localparam int FLSB_IN2_W = 8;
  localparam int FLSB_OUT_W = 4;
  localparam int FLSB_OUT2_W = 5;
  localparam int FLSB_INT1_W = 8;
  localparam int FLSB_ADC_W = 2;

  // host request on the control port, one cycle per access
  typedef struct packed {
    logic req;
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flsb_req_s;

  // answer to a host request
  typedef struct packed {
    logic ack;
    logic [7:0] rdata;
  } flsb_rsp_s;

  // second input channel fault conditions, live levels from analog
  typedef struct packed {
    logic open_input;
    logic inputs_shorted;
    logic pos_to_gnd;
    logic neg_to_gnd;
    logic pos_to_bias;
    logic neg_to_bias;
    logic pos_to_batt;
    logic neg_to_batt;
  } flsb_in_fault_s;

  // one output channel fault conditions
  typedef struct packed {
    logic pos_pin_short;
    logic neg_pin_short;
    logic pos_driver_vgnd;
    logic neg_driver_vgnd;
  } flsb_out_fault_s;

  // latched interrupt group sources
  typedef struct packed {
    logic ch1_pos_ovp;
    logic ch1_neg_ovp;
    logic ch2_pos_ovp;
    logic ch2_neg_ovp;
    logic headset_insert;
    logic headset_remove;
    logic headset_hook;
    logic processing_capacity_overload;
  } flsb_int_src_s;

endpackage

/* flsb_top.sv */
// fault latch status bank: latched diagnostics, masks and the control port
`timescale 1ns/1ps

// What this block does
// [R1] input2 bit 7 latches an open input, cleared by reading
// [R2] input2 bit 6 latches the two inputs shorted together, cleared by reading
// [R3] input2 bits 5 and 4 latch positive and negative input short to ground
// [R4] input2 bits 3 and 2 latch positive and negative input short to bias
// [R5] input2 bits 1 and 0 latch positive and negative input short to battery
// [R6] output1 bits 7 and 6 latch pin short circuits, cleared by reading
// [R7] output1 bits 5 and 4 latch driver virtual-ground faults
// [R8] output1 bits 3 and 2 are writable adc overload masks, reset zero
// [R9] reserved bits read zero; host writes only zero there
// [R10] output2 bits 7 and 6 latch pin short circuits
// [R11] output2 bits 5 and 4 latch driver virtual-ground faults
// [R12] output2 bit 1 is the writable regulator short mask
// [R13] output2 bit 0 latches the regulator short, reads zero otherwise
// [R14] interrupt group bits 7 to 4 latch input over-voltage per pin
// [R15] interrupt group bits 3 and 2 latch headset insert and remove
// [R16] interrupt group bit 1 latches the headset hook button
// [R17] interrupt group bit 0 latches processing capacity overload
// [R18] output1 register sits at 0x38 and resets to 0x00
// [R19] interrupt group register sits at 0x3A, resets 0x00, read only
// [R20] channel summary flag for input2 is set while any input2 fault latched
// [R21] latched bits hold until read, then follow the still present condition
// [R22] a masked regulator short still latches; masked faults do not drive the interrupt output
module flsb_top (
  input wire logic clk,
  input wire logic rst,
  input wire flsb_pkg::flsb_req_s host_req,
  output flsb_pkg::flsb_rsp_s host_rsp,
  input wire flsb_pkg::flsb_in_fault_s in2_fault,
  input wire flsb_pkg::flsb_out_fault_s out1_fault,
  input wire flsb_pkg::flsb_out_fault_s out2_fault,
  input wire logic analog_regulator_short,
  input wire logic adc1_overload,
  input wire logic adc2_overload,
  input wire flsb_pkg::flsb_int_src_s int_src,
  output logic channel_summary_fault_flag,
  output logic fault_irq
);
  import flsb_pkg::*;

  typedef struct packed {
    logic adc1_overload_mask;
    logic adc2_overload_mask;
    logic regulator_short_mask;
    flsb_rsp_s rsp;
    logic summary;
    logic irq;
  } flsb_state_s;

  flsb_state_s st_ff;
  flsb_state_s nxt_st;

  logic rd_in2;
  logic rd_out1;
  logic rd_out2;
  logic rd_int1;
  logic wr_out1;
  logic wr_out2;

  logic [FLSB_IN2_W-1:0] in2_lat;
  logic [FLSB_OUT_W-1:0] out1_lat;
  logic [FLSB_OUT2_W-1:0] out2_lat;
  logic [FLSB_INT1_W-1:0] int1_lat;
  logic [FLSB_ADC_W-1:0] adc_live;

  logic [7:0] in2_word;
  logic [7:0] out1_word;
  logic [7:0] out2_word;
  logic [7:0] int1_word;
  logic [7:0] rd_word;
  logic unmasked_any;

  // address decode; a read clears the latches of that one register
  assign rd_in2 = host_req.req && !host_req.we && (host_req.addr == FLSB_ADDR_IN2); // [R21]
  assign rd_out1 = host_req.req && !host_req.we && (host_req.addr == FLSB_ADDR_OUT1); // [R18]
  assign rd_out2 = host_req.req && !host_req.we && (host_req.addr == FLSB_ADDR_OUT2);
  assign rd_int1 = host_req.req && !host_req.we && (host_req.addr == FLSB_ADDR_INT1); // [R19]
  assign wr_out1 = host_req.req && host_req.we && (host_req.addr == FLSB_ADDR_OUT1);
  assign wr_out2 = host_req.req && host_req.we && (host_req.addr == FLSB_ADDR_OUT2);

  // second input channel latches, bit order follows the struct
  flsb_latch_bank #(.W(FLSB_IN2_W)) u_in2 (
    .clk(clk),
    .rst(rst),
    .cond(in2_fault), // [R1] [R2] [R3] [R4] [R5]
    .clr(rd_in2),
    .latched(in2_lat),
    .live()
  );

  // first output channel pin shorts and virtual-ground faults
  flsb_latch_bank #(.W(FLSB_OUT_W)) u_out1 (
    .clk(clk),
    .rst(rst),
    .cond(out1_fault), // [R6] [R7]
    .clr(rd_out1),
    .latched(out1_lat),
    .live()
  );

  // second output channel plus the regulator short in the low bit
  flsb_latch_bank #(.W(FLSB_OUT2_W)) u_out2 (
    .clk(clk),
    .rst(rst),
    .cond({out2_fault, analog_regulator_short}), // [R10] [R11] [R13]
    .clr(rd_out2),
    .latched(out2_lat),
    .live()
  );

  // interrupt group sources
  flsb_latch_bank #(.W(FLSB_INT1_W)) u_int1 (
    .clk(clk),
    .rst(rst),
    .cond(int_src), // [R14] [R15] [R16] [R17]
    .clr(rd_int1),
    .latched(int1_lat),
    .live()
  );

  // adc overload has no readable latch here; only its live level gates the irq
  flsb_latch_bank #(.W(FLSB_ADC_W)) u_adc (
    .clk(clk),
    .rst(rst),
    .cond({adc1_overload, adc2_overload}),
    .clr(1'b1),
    .latched(),
    .live(adc_live)
  );

  // register images; reserved bits tie to zero whatever the host wrote
  always_comb begin
    in2_word = in2_lat;
    out1_word = '0; // [R9]
    out1_word[FLSB_O1_FAULT_LSB +: FLSB_OUT_W] = out1_lat;
    out1_word[FLSB_O1_ADC1_MASK_BIT] = st_ff.adc1_overload_mask;
    out1_word[FLSB_O1_ADC2_MASK_BIT] = st_ff.adc2_overload_mask;
    out2_word = '0; // [R9]
    out2_word[FLSB_O2_FAULT_LSB +: FLSB_OUT_W] = out2_lat[FLSB_OUT2_W-1:1];
    out2_word[FLSB_O2_REG_MASK_BIT] = st_ff.regulator_short_mask;
    out2_word[FLSB_O2_REG_LATCH_BIT] = out2_lat[0]; // [R13]
    int1_word = int1_lat;
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    case (host_req.addr)
      FLSB_ADDR_IN2: rd_word = in2_word;
      FLSB_ADDR_OUT1: rd_word = out1_word;
      FLSB_ADDR_OUT2: rd_word = out2_word;
      FLSB_ADDR_INT1: rd_word = int1_word;
      default: rd_word = FLSB_RDATA_NONE;
    endcase
  end

  // a masked regulator short stays visible in status; all masked faults are kept off the irq
  always_comb begin
    unmasked_any = (|in2_lat) | (|out1_lat) | (|out2_lat[FLSB_OUT2_W-1:1]) | (|int1_lat);
    unmasked_any = unmasked_any | (out2_lat[0] & ~st_ff.regulator_short_mask); // [R22]
    unmasked_any = unmasked_any | (adc_live[1] & ~st_ff.adc1_overload_mask); // [R22]
    unmasked_any = unmasked_any | (adc_live[0] & ~st_ff.adc2_overload_mask); // [R22]
  end

  // next state: masks, answer, summary and irq
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rsp.ack = host_req.req;
    if (host_req.req && !host_req.we) begin
      // data captured before the same edge clears the latch
      nxt_st.rsp.rdata = rd_word; // [R21]
    end
    if (wr_out1) begin
      nxt_st.adc1_overload_mask = host_req.wdata[FLSB_O1_ADC1_MASK_BIT]; // [R8]
      nxt_st.adc2_overload_mask = host_req.wdata[FLSB_O1_ADC2_MASK_BIT]; // [R8]
    end
    if (wr_out2) begin
      nxt_st.regulator_short_mask = host_req.wdata[FLSB_O2_REG_MASK_BIT]; // [R12]
    end
    nxt_st.summary = |in2_lat; // [R20]
    nxt_st.irq = unmasked_any;
  end

  // register stage; all controls reset to zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign host_rsp = st_ff.rsp;
  assign channel_summary_fault_flag = st_ff.summary;
  assign fault_irq = st_ff.irq;
endmodule

/* tb.sv */
// self-checking bench for the fault latch status bank
`timescale 1ns/1ps
module tb;
  import flsb_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic act = 1'b0;
  logic [31:0] p1 = 32'h0;
  logic [31:0] w;
  logic [31:0] rng = 32'h953D;
  logic [1:0] m38 = 2'h0;
  logic m39 = 1'b0;
  logic [8:0] got;
  logic [7:0] addrs [5] = '{8'h37, 8'h38, 8'h39, 8'h3A, 8'h40};
  flsb_req_s host_req;
  flsb_rsp_s host_rsp;
  flsb_in_fault_s in2;
  flsb_out_fault_s o1;
  flsb_out_fault_s o2;
  flsb_int_src_s isrc;
  logic analog_regulator;
  logic adc1;
  logic adc2;
  logic summ;
  logic irq;
  int bad_count = 0;
  int n_compared = 0;
  always #50 clk = ~clk;
  // fault pattern reaches the pins only while act is up; overloads stay live
  assign in2 = act ? p1[7:0] : 8'h00;
  assign o1 = act ? p1[11:8] : 4'h0;
  assign o2 = act ? p1[15:12] : 4'h0;
  assign isrc = act ? p1[23:16] : 8'h00;
  assign analog_regulator = act & p1[24];
  assign adc1 = p1[25];
  assign adc2 = p1[26];
  flsb_top dut_u (.clk(clk), .rst(rst), .host_req(host_req), .host_rsp(host_rsp),
    .in2_fault(in2), .out1_fault(o1), .out2_fault(o2), .analog_regulator_short(analog_regulator),
    .adc1_overload(adc1), .adc2_overload(adc2), .int_src(isrc),
    .channel_summary_fault_flag(summ), .fault_irq(irq));
  flsb_host_model host_u (.clk(clk), .host_req(host_req), .host_rsp(host_rsp));
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // register image; on selects whether the pattern is still latched
  function automatic logic [7:0] img(input logic [7:0] a, input logic on);
    case (a)
      FLSB_ADDR_IN2: return on ? p1[7:0] : 8'h00;
      FLSB_ADDR_OUT1: return {on ? p1[11:8] : 4'h0, m38, 2'h0};
      FLSB_ADDR_OUT2: return {on ? p1[15:12] : 4'h0, 2'h0, m39, on & p1[24]};
      FLSB_ADDR_INT1: return on ? p1[23:16] : 8'h00;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic irq_exp();
    return (|p1[23:0]) | (p1[24] & !m39) | (p1[25] & !m38[1]) | (p1[26] & !m38[0]);
  endfunction
  task automatic cmp(input logic [8:0] g, input logic [8:0] e);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    // reset images, unmapped place included
    for (int i = 0; i < 5; i++) begin
      host_u.rd(addrs[i], got);
      cmp(got, {1'b1, img(addrs[i], 1'b0)});
    end
    repeat (12) begin
      p1 = rnd();
      w = rnd();
      m38 = w[11:10];
      m39 = w[17];
      // write then read back to back, read-only group included
      for (int i = 1; i < 4; i++) begin
        host_u.wr(addrs[i], w[8*i+:8]);
        host_u.rd(addrs[i], got);
        cmp(got, {1'b1, img(addrs[i], 1'b0)});
      end
      @(negedge clk);
      act = 1'b1;
      repeat (3) @(negedge clk);
      act = 1'b0;
      repeat (4) @(negedge clk);
      cmp({8'h00, summ}, {8'h00, |p1[7:0]});
      cmp({8'h00, irq}, {8'h00, irq_exp()});
      // first pass shows the held faults, second finds them cleared
      for (int k = 0; k < 2; k++) begin
        host_u.rd(FLSB_ADDR_IN2, got);
        cmp(got, {1'b1, img(FLSB_ADDR_IN2, k == 0)});
        host_u.rd(FLSB_ADDR_OUT1, got);
        cmp(got, {1'b1, img(FLSB_ADDR_OUT1, k == 0)});
        host_u.rd(FLSB_ADDR_OUT2, got);
        cmp(got, {1'b1, img(FLSB_ADDR_OUT2, k == 0)});
        host_u.rd(FLSB_ADDR_INT1, got);
        cmp(got, {1'b1, img(FLSB_ADDR_INT1, k == 0)});
      end
      cmp({8'h00, summ}, 9'h000);
    end
    // a condition still present sets the latch again after the read
    p1 = 32'h81;
    @(negedge clk);
    act = 1'b1;
    repeat (4) @(negedge clk);
    repeat (2) begin
      host_u.rd(FLSB_ADDR_IN2, got);
      cmp(got, 9'h181);
    end
    report_and_stop();
  end
endmodule
